/* File: rtl/vgc_vertical_gate.sv */
// Module: vertical gate, field identifier, clock output enables and raw gain registers
`timescale 1ns/1ns
module vgc_vertical_gate #(
  parameter int SAMPLE_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_line_start,
  input wire logic i_field_start,
  input wire logic i_field2,
  input wire logic i_is_60hz,
  input wire logic [SAMPLE_W-1:0] i_raw_sample,
  input wire logic i_raw_valid,
  output logic [SAMPLE_W:0] o_raw_scaled,
  output logic o_raw_scaled_valid,
  output logic o_vertical_gate,
  output logic o_field_identifier,
  output logic o_line_locked_clock_oe,
  output logic o_half_rate_line_clock_oe
);
  import vgc_pkg::*;

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  if (SAMPLE_W < 1 || SAMPLE_W > 16) begin : g_bad_width
    $error("vgc_vertical_gate: SAMPLE_W must be 1 to 16");
  end

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [7:0] start_low;
    logic [7:0] stop_low;
    logic [7:0] misc;
    logic [7:0] gain;
    logic [7:0] rdata;
    logic [8:0] line_count;
    logic field2;
    vgc_gate_t gate;
    logic field_identifier;
  } vgc_state_t;

  localparam vgc_state_t VGC_RST_STATE = '{
    start_low: VGC_RST_START_LOW,
    stop_low: VGC_RST_STOP_LOW,
    misc: VGC_RST_MISC,
    gain: VGC_RST_GAIN,
    rdata: 8'h00,
    line_count: 9'h000,
    field2: 1'b0,
    gate: VGC_GATE_LOW,
    field_identifier: 1'b0
  };

  vgc_state_t s;
  vgc_state_t next_s;
  logic [8:0] wrap;
  logic [8:0] start_val;
  logic [8:0] stop_val;
  logic [8:0] cmp_line;
  logic hit_start;
  logic hit_stop;

  // Nine-bit positions: msb lives in the misc register
  assign start_val = {s.misc[VGC_MISC_START_MSB], s.start_low};
  assign stop_val = {s.misc[VGC_MISC_STOP_MSB], s.stop_low};

  // Highest programmed value of the running standard
  assign wrap = i_is_60hz ? VGC_WRAP_60 : VGC_WRAP_50;

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  // The counter holds the programmed value of the current line, so the
  // compare is a plain equality. Field 1 loads the top value and field 2
  // one less, which places value 0 on the second line of field 1 and
  // the third line of field 2, the same in both standards.
  always_comb begin
    next_s = s;
    cmp_line = s.line_count;
    hit_start = 1'b0;
    hit_stop = 1'b0;

    // Register writes; reserved misc bits are never stored
    if (i_wr) begin
      case (i_addr)
        VGC_ADDR_START_LOW: next_s.start_low = i_wdata;
        VGC_ADDR_STOP_LOW: next_s.stop_low = i_wdata;
        VGC_ADDR_MISC: next_s.misc = i_wdata & VGC_MISC_MASK;
        VGC_ADDR_GAIN: next_s.gain = i_wdata;
        default: next_s.misc = s.misc;
      endcase
    end

    // Read data stand for one cycle only, zero otherwise and when unmapped
    next_s.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        VGC_ADDR_START_LOW: next_s.rdata = s.start_low;
        VGC_ADDR_STOP_LOW: next_s.rdata = s.stop_low;
        VGC_ADDR_MISC: next_s.rdata = s.misc;
        VGC_ADDR_GAIN: next_s.rdata = s.gain;
        VGC_ADDR_STATUS: begin
          next_s.rdata[VGC_STAT_GATE] = (s.gate == VGC_GATE_HIGH);
          next_s.rdata[VGC_STAT_FID] = s.field_identifier;
          next_s.rdata[VGC_STAT_FIELD2] = s.field2;
          next_s.rdata[VGC_STAT_CNT_MSB] = s.line_count[8];
        end
        VGC_ADDR_COUNT: next_s.rdata = s.line_count[7:0];
        default: next_s.rdata = 8'h00;
      endcase
    end

    // Line stepping, once per line
    if (i_line_start) begin
      if (i_field_start) begin
        next_s.field2 = i_field2;
        // Field 1 starts at the top value, field 2 one below
        next_s.line_count = i_field2 ? 9'(wrap - 9'h001) : wrap;
      end else if (s.line_count >= wrap) begin
        next_s.line_count = 9'h000;
      end else begin
        next_s.line_count = 9'(s.line_count + 9'h001);
      end

      // Alternative position: look one line ahead in field 2
      cmp_line = next_s.line_count;
      if (s.misc[VGC_MISC_ALT_POS] && next_s.field2) begin
        cmp_line = (next_s.line_count >= wrap) ? 9'h000 : 9'(next_s.line_count + 9'h001);
      end
      hit_start = (cmp_line == start_val);
      hit_stop = (cmp_line == stop_val);

      // Field identifier flips on every start match
      if (hit_start) begin
        next_s.field_identifier = ~s.field_identifier;
      end

      // Equal start and stop give no pulse: stop is checked last
      case (s.gate)
        VGC_GATE_LOW: begin
          if (hit_start && !hit_stop) begin
            next_s.gate = VGC_GATE_HIGH;
          end
        end
        VGC_GATE_HIGH: begin
          if (hit_stop) begin
            next_s.gate = VGC_GATE_LOW;
          end
        end
        default: next_s.gate = VGC_GATE_LOW;
      endcase
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Clock enable low freezes everything, register port included
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= VGC_RST_STATE;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Raw sample gain
  // ==========================================================================
  vgc_gain_if #(.SAMPLE_W(SAMPLE_W)) gain_bus ();

  assign gain_bus.gain = s.gain;
  assign gain_bus.sample = i_raw_sample;
  assign gain_bus.sample_valid = i_raw_valid;

  vgc_gain #(.SAMPLE_W(SAMPLE_W)) u_gain (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .bus(gain_bus.scaler)
  );

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign o_rdata = s.rdata;
  assign o_raw_scaled = gain_bus.scaled;
  assign o_raw_scaled_valid = gain_bus.scaled_valid;
  assign o_vertical_gate = (s.gate == VGC_GATE_HIGH);
  assign o_field_identifier = s.field_identifier;
  // A set bit floats the pin, so enables are inverted
  assign o_line_locked_clock_oe = ~s.misc[VGC_MISC_CLK_DIS];
  assign o_half_rate_line_clock_oe = ~s.misc[VGC_MISC_HALF_CLK_DIS];

endmodule : vgc_vertical_gate

/* File: pkg/vgc_pkg.sv */
// Package: register map, field positions, reset values and line constants for the vertical gate
package vgc_pkg;

  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] VGC_ADDR_START_LOW = 8'h15;
  localparam logic [7:0] VGC_ADDR_STOP_LOW = 8'h16;
  localparam logic [7:0] VGC_ADDR_MISC = 8'h17;
  localparam logic [7:0] VGC_ADDR_GAIN = 8'h18;
  localparam logic [7:0] VGC_ADDR_STATUS = 8'h1A;
  localparam logic [7:0] VGC_ADDR_COUNT = 8'h1B;

  // ==========================================================================
  // Field positions in the misc register
  // ==========================================================================
  localparam int unsigned VGC_MISC_START_MSB = 0;
  localparam int unsigned VGC_MISC_STOP_MSB = 1;
  localparam int unsigned VGC_MISC_ALT_POS = 2;
  localparam int unsigned VGC_MISC_HALF_CLK_DIS = 6;
  localparam int unsigned VGC_MISC_CLK_DIS = 7;
  // Bits 5..3 are reserved and read as zero
  localparam logic [7:0] VGC_MISC_MASK = 8'hC7;

  // Field positions in the status register
  localparam int unsigned VGC_STAT_GATE = 0;
  localparam int unsigned VGC_STAT_FID = 1;
  localparam int unsigned VGC_STAT_FIELD2 = 2;
  localparam int unsigned VGC_STAT_CNT_MSB = 3;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] VGC_RST_START_LOW = 8'h00;
  localparam logic [7:0] VGC_RST_STOP_LOW = 8'h00;
  localparam logic [7:0] VGC_RST_MISC = 8'h00;
  localparam logic [7:0] VGC_RST_GAIN = 8'h80;

  // ==========================================================================
  // Line counting: highest programmed value per standard
  // ==========================================================================
  localparam logic [8:0] VGC_WRAP_50 = 9'h138;
  localparam logic [8:0] VGC_WRAP_60 = 9'h106;
  // Nominal gain 128 is unity, so the product is shifted by seven
  localparam int unsigned VGC_GAIN_SHIFT = 7;

  // Gate output state
  typedef enum logic {
    VGC_GATE_LOW,
    VGC_GATE_HIGH
  } vgc_gate_t;

endpackage : vgc_pkg

/* File: pkg/vgc_gain_if.sv */
// Interface: carries raw samples and gain to the scaler and scaled samples back
`timescale 1ns/1ns
interface vgc_gain_if #(
  parameter int SAMPLE_W = 8
);
  logic [7:0] gain;
  logic [SAMPLE_W-1:0] sample;
  logic sample_valid;
  logic [SAMPLE_W:0] scaled;
  logic scaled_valid;

  modport core (output gain, output sample, output sample_valid, input scaled, input scaled_valid);
  modport scaler (input gain, input sample, input sample_valid, output scaled, output scaled_valid);
endinterface : vgc_gain_if

/* File: rtl/vgc_gain.sv */
// Module: raw sample gain scaler, one registered stage
`timescale 1ns/1ns
module vgc_gain #(
  parameter int SAMPLE_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  vgc_gain_if.scaler bus
);
  import vgc_pkg::*;

  // ==========================================================================
  // Parameter check
  // ==========================================================================
  if (SAMPLE_W < 1 || SAMPLE_W > 16) begin : g_bad_width
    $error("vgc_gain: SAMPLE_W must be 1 to 16");
  end

  typedef struct packed {
    logic [SAMPLE_W:0] scaled;
    logic valid;
  } vgc_gain_state_t;

  vgc_gain_state_t s;
  vgc_gain_state_t next_s;
  logic [SAMPLE_W+7:0] product;

  // ==========================================================================
  // Scaling: 0 silences, 128 passes, 255 nearly doubles
  // ==========================================================================
  // One extra output bit keeps double amplitude from clipping
  always_comb begin
    product = SAMPLE_W'(bus.sample) * bus.gain;
    next_s = s;
    next_s.valid = bus.sample_valid;
    if (bus.sample_valid) begin
      next_s.scaled = product[SAMPLE_W+VGC_GAIN_SHIFT:VGC_GAIN_SHIFT];
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
    end else if (i_ce) begin
      s <= next_s;
    end
  end

  assign bus.scaled = s.scaled;
  assign bus.scaled_valid = s.valid;

endmodule : vgc_gain

/* File: verif/vgc_chk.sv */
// Checker: port-level assertions for the vertical gate block
`timescale 1ns/1ns
module vgc_chk #(
  parameter int SAMPLE_W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_line_start,
  input wire logic [SAMPLE_W-1:0] i_raw_sample,
  input wire logic i_raw_valid,
  input wire logic [SAMPLE_W:0] o_raw_scaled,
  input wire logic o_raw_scaled_valid,
  input wire logic o_vertical_gate,
  input wire logic o_field_identifier,
  input wire logic o_line_locked_clock_oe,
  input wire logic o_half_rate_line_clock_oe
);
  import vgc_pkg::*;
  logic [7:0] gain;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ==========================================================================
  // Shadow of the gain register, so scaled samples can be predicted
  // ==========================================================================
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gain <= VGC_RST_GAIN;
    end else if (i_ce && i_wr && i_addr == VGC_ADDR_GAIN) begin
      gain <= i_wdata;
    end
  end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_clk_oe_follow: assert property (i_ce && i_wr && i_addr == VGC_ADDR_MISC
    |=> o_line_locked_clock_oe == !$past(i_wdata[7])) else $error("clock oe wrong");
  a_half_oe_follow: assert property (i_ce && i_wr && i_addr == VGC_ADDR_MISC
    |=> o_half_rate_line_clock_oe == !$past(i_wdata[6])) else $error("half oe wrong");
  // A frozen block keeps its read data, so only a running idle cycle clears it
  a_rdata_idle_zero: assert property (i_ce && !i_rd
    |=> o_rdata == 8'h00) else $error("read data not cleared");
  a_gain_read_back: assert property (i_ce && i_rd && i_addr == VGC_ADDR_GAIN
    |=> o_rdata == $past(gain)) else $error("gain read back wrong");
  a_gate_line_only: assert property (!(i_ce && i_line_start)
    |=> $stable(o_vertical_gate)) else $error("gate moved off a line");
  a_fid_line_only: assert property (!(i_ce && i_line_start)
    |=> $stable(o_field_identifier)) else $error("field id moved off a line");
  a_scaled_valid: assert property (i_ce
    |=> o_raw_scaled_valid == $past(i_raw_valid)) else $error("scaled valid wrong");
  a_scaled_value: assert property (i_ce && i_raw_valid |=> o_raw_scaled ==
    (SAMPLE_W+1)'((32'($past(i_raw_sample)) * 32'($past(gain))) >> 7))
    else $error("scaled value wrong");
endmodule : vgc_chk

bind vgc_vertical_gate vgc_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_line_start(i_line_start), .i_raw_sample(i_raw_sample),
  .i_raw_valid(i_raw_valid), .o_raw_scaled(o_raw_scaled),
  .o_raw_scaled_valid(o_raw_scaled_valid), .o_vertical_gate(o_vertical_gate),
  .o_field_identifier(o_field_identifier), .o_line_locked_clock_oe(o_line_locked_clock_oe),
  .o_half_rate_line_clock_oe(o_half_rate_line_clock_oe));

/* File: verif/vgc_sync_model.sv */
// Partner: sync source with short lines and 50/60 Hz frame line counting
`timescale 1ns/1ns
module vgc_sync_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_is_60hz,
  output logic o_line_start,
  output logic o_field_start,
  output logic o_field2,
  output logic [9:0] o_frame_line
);
  logic [1:0] phase;
  logic [9:0] nxt;
  // Field openings: lines 1/313 at 50 Hz, 4/266 at 60 Hz
  assign nxt = (o_frame_line >= (i_is_60hz ? 10'h20D : 10'h271)) ? 10'h001 :
    10'(o_frame_line + 10'h001);
  // Four clocks a line keeps whole frames short; field start rides the line pulse
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phase <= 2'h0;
      o_frame_line <= 10'h001;
      o_line_start <= 1'b0;
      o_field_start <= 1'b0;
      o_field2 <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      o_line_start <= (phase == 2'h3);
      o_field_start <= 1'b0;
      if (phase == 2'h3) begin
        o_frame_line <= nxt;
        o_field_start <= (nxt == (i_is_60hz ? 10'h004 : 10'h001)) ||
          (nxt == (i_is_60hz ? 10'h10A : 10'h139));
        if (nxt == (i_is_60hz ? 10'h10A : 10'h139)) begin
          o_field2 <= 1'b1;
        end else if (nxt == (i_is_60hz ? 10'h004 : 10'h001)) begin
          o_field2 <= 1'b0;
        end
      end
    end
  end
endmodule : vgc_sync_model

/* File: verif/test_vertical_gate_and_misc_ctrl.sv */
// Testbench: registers, gate timing, clock enables and raw gain
`timescale 1ns/1ns
module test_vertical_gate_and_misc_ctrl;
  import vgc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_is_60hz = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_raw_valid = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] i_raw_sample = 8'h00;
  logic [7:0] o_rdata;
  logic [8:0] o_raw_scaled;
  logic [9:0] fl;
  logic scv, gate, field_identifier, line_locked_clock, half, ls, fs, f2;
  int mismatches = 0;
  int cmp_count = 0;
  always #50 i_clk = ~i_clk;
  // Clock enable is dropped only by the freeze scenario
  vgc_vertical_gate DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_line_start(ls),
    .i_field_start(fs), .i_field2(f2), .i_is_60hz(i_is_60hz), .i_raw_sample(i_raw_sample),
    .i_raw_valid(i_raw_valid), .o_raw_scaled(o_raw_scaled), .o_raw_scaled_valid(scv),
    .o_vertical_gate(gate), .o_field_identifier(field_identifier), .o_line_locked_clock_oe(line_locked_clock),
    .o_half_rate_line_clock_oe(half));
  vgc_sync_model u_sync (.i_clk(i_clk), .i_rst(i_rst), .i_is_60hz(i_is_60hz),
    .o_line_start(ls), .o_field_start(fs), .o_field2(f2), .o_frame_line(fl));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 check(32'(o_rdata), 32'(exp));
  endtask : rd_chk
  // Reset values, reserved bits, unmapped read, clock output enables
  task automatic test_regs;
    // No line has been taken yet: count and status still read zero
    rd_chk(VGC_ADDR_COUNT, 8'h00);
    rd_chk(VGC_ADDR_STATUS, 8'h00);
    rd_chk(VGC_ADDR_START_LOW, 8'h00);
    rd_chk(VGC_ADDR_STOP_LOW, 8'h00);
    rd_chk(VGC_ADDR_MISC, 8'h00);
    rd_chk(VGC_ADDR_GAIN, 8'h80);
    rd_chk(8'h30, 8'h00);
    check(32'({line_locked_clock, half}), 32'h00000003);
    wr(VGC_ADDR_MISC, 8'hFF);
    rd_chk(VGC_ADDR_MISC, 8'hC7);
    check(32'({line_locked_clock, half}), 32'h00000000);
    wr(VGC_ADDR_MISC, 8'h40);
    check(32'({line_locked_clock, half}), 32'h00000002);
    wr(VGC_ADDR_MISC, 8'h80);
    check(32'({line_locked_clock, half}), 32'h00000001);
    $display("test regs finished");
  endtask : test_regs
  // One frame watched: frame lines of gate edges and field id flips
  task automatic gate_frame(input logic hz, input logic [8:0] sta, input logic [8:0] sto,
      input logic alt, input logic [39:0] exp);
    logic [9:0] r1, r2, e1, e2, t1, t2;
    logic pg, pf;
    {r1, r2, e1, e2} = {4{10'h3FF}};
    {t1, t2} = {2{10'h3FF}};
    @(posedge i_clk);
    i_is_60hz <= hz;
    wr(VGC_ADDR_START_LOW, sta[7:0]);
    wr(VGC_ADDR_STOP_LOW, sto[7:0]);
    wr(VGC_ADDR_MISC, {5'h00, alt, sto[8], sta[8]});
    repeat (2600) @(posedge i_clk);
    #1 pg = gate;
    pf = field_identifier;
    repeat (2600) begin
      @(posedge i_clk);
      #1;
      if (gate && !pg) begin
        if (f2) r2 = fl; else r1 = fl;
      end
      if (!gate && pg) begin
        if (f2) e2 = fl; else e1 = fl;
      end
      if (field_identifier !== pf) begin
        if (f2) t2 = fl; else t1 = fl;
      end
      pg = gate;
      pf = field_identifier;
    end
    check(32'({r1, r2}), 32'(exp[39:20]));
    check(32'({e1, e2}), 32'(exp[19:0]));
    check(32'({t1, t2}), 32'(exp[39:20]));
    $display("gate frame finished");
  endtask : gate_frame
  // Sample times gain, product shifted down by seven
  task automatic gain_case(input logic [7:0] g, input logic [7:0] s, input logic [8:0] exp);
    wr(VGC_ADDR_GAIN, g);
    @(posedge i_clk);
    i_raw_sample <= s;
    i_raw_valid <= 1'b1;
    @(posedge i_clk);
    i_raw_valid <= 1'b0;
    #1 check(32'({scv, o_raw_scaled}), 32'({1'b1, exp}));
    $display("gain case finished");
  endtask : gain_case
  // Clock enable low: a write is ignored and the old gain reads back
  task automatic test_ce;
    @(posedge i_clk);
    i_ce <= 1'b0;
    wr(VGC_ADDR_GAIN, 8'h11);
    @(posedge i_clk);
    i_ce <= 1'b1;
    rd_chk(VGC_ADDR_GAIN, 8'h80);
    $display("test ce finished");
  endtask : test_ce
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    test_regs();
    gate_frame(1'b0, 9'h000, 9'h136, 1'b0, {10'h002, 10'h13B, 10'h138, 10'h271});
    gate_frame(1'b0, 9'h138, 9'h000, 1'b0, {10'h001, 10'h13A, 10'h002, 10'h13B});
    gate_frame(1'b0, 9'h000, 9'h136, 1'b1, {10'h002, 10'h13A, 10'h138, 10'h270});
    gate_frame(1'b1, 9'h000, 9'h104, 1'b0, {10'h005, 10'h10C, 10'h109, 10'h003});
    gate_frame(1'b1, 9'h106, 9'h000, 1'b0, {10'h004, 10'h10B, 10'h005, 10'h10C});
    gain_case(8'h00, 8'hFF, 9'h000);
    gain_case(8'h80, 8'hFF, 9'h0FF);
    gain_case(8'hFF, 8'hFF, 9'h1FC);
    gain_case(8'h80, 8'h40, 9'h040);
    test_ce();
    give_verdict();
  end
endmodule : test_vertical_gate_and_misc_ctrl
